// file: core_regs_map.vh
// address map, field positions and vectors for the core register block
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH
`define ADDR_POINTER_FIRST 8'h80
`define ADDR_POINTER_SECOND 8'h81
`define ADDR_SHORT_SLOT_ONE 8'h82
`define ADDR_SHORT_SLOT_B 8'h83
`define ADDR_ROM_WINDOW_BASE 8'hc9
`define ADDR_SUM_REGISTER 8'hff
`define WINDOW_LO 8'h40
`define WINDOW_HI 8'h7f
`define WINDOW_BASE_BITS 6
`define VEC_IRQ_BASE 12'h0ff0
`define VEC_NMI 12'h0ffc
`define VEC_RESET 12'h0ffe
`define OPT_CLOCK_GUARD_EN_BIT 0
`define OPT_WATCHDOG_HW_START_BIT 1
`define OPT_TIMER_PIN_PULLUP_EN_BIT 2
`define OPT_NMI_PULL_BIT 3
`define OPT_OSC_SOURCE_SELECT_BIT 6
`define OPT_PROTECT_BIT 7
`define OPT_LVD_BIT 8
`define OPT_STOP_WITH_WATCHDOG_EN_BIT 9
`endif

// file: option_latch.v
// option byte capture at reset release
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_map.vh"
module option_latch (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [15:0] opt_word_i,
  output reg [15:0] opt_q_o,
  output reg opt_valid_o
);
  // capture on the first clock after release; async reset loads constants only
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_q_o <= 16'h0000;
      opt_valid_o <= 1'b0;
    end else if (!opt_valid_o) begin
      opt_q_o <= opt_word_i;
      opt_valid_o <= 1'b1; // held until next reset
    end
  end
endmodule // option_latch
`default_nettype wire

// file: sync2.v
// two flop synchroniser for a level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire d_i,
  output reg q_o
);
  reg meta_q;
  // first stage feeds only the second
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // sync2
`default_nettype wire

// file: core_regs.v
// core working registers, rom window, fetch counter and option outputs
// Operation
// - window base holds six upper address bits
// - window base is write only
// - window base not cleared by reset
// - option bytes fetched at chip reset
// - options reachable only in programming mode
// - stop with watchdog needs option, nmi high
// - low supply reset only when enabled
// - protect bit blocks external program readout
// - oscillator source: crystal low, rc high
// - pull-up options for nmi and timer pins
// - watchdog start: hardware high, software low
// - clock guard enabled when bit high
// - vectors fetched from fixed top locations
// - accumulator mapped at data address ff
// - pointer registers mapped at 80, 81
// - indirect mode uses pointer register contents
// - short direct registers mapped at 82, 83
// - fetch counter twelve bits wide
// - window reads return program memory bytes
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_map.vh"
module core_regs #(
  parameter PC_W = 12
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  // data space access from the cpu
  input wire [7:0] d_addr_i,
  input wire d_wr_i,
  input wire d_rd_i,
  input wire [7:0] d_wdata_i,
  input wire d_indirect_i,
  input wire d_ind_sel_i,
  output reg [7:0] d_rdata_o,
  output reg [7:0] d_eff_addr_o,
  // accumulator direct update from alu
  input wire acc_load_i,
  input wire [7:0] acc_data_i,
  output reg [7:0] sum_register_o,
  // fetch counter control
  input wire pc_inc_i,
  input wire pc_load_i,
  input wire [PC_W-1:0] pc_load_addr_i,
  input wire vec_irq_i,
  input wire [1:0] vec_irq_num_i,
  input wire vec_nmi_i,
  output reg [PC_W-1:0] fetch_counter_o,
  // program memory port, shared by fetch and window reads
  output reg [PC_W-1:0] pmem_addr_o,
  input wire [7:0] pmem_data_i,
  // programming mode and option access
  input wire prog_mode_i,
  input wire [15:0] opt_word_i,
  input wire ext_read_req_i,
  output reg ext_read_en_o,
  // pins and watchdog state
  input wire nmi_pin_i,
  input wire watchdog_active_i,
  input wire stop_req_i,
  input wire low_supply_i,
  output reg stop_allow_o,
  output reg low_supply_rst_o,
  output reg stop_with_watchdog_en_o,
  output reg low_supply_reset_en_o,
  output reg osc_source_select_o,
  output reg timer_pin_pullup_en_o,
  output reg nmi_pin_pullup_en_o,
  output reg watchdog_hw_start_o,
  output reg clock_guard_en_o,
  output reg readout_protect_o
);
  reg [7:0] pointer_first_q;
  reg [7:0] pointer_second_q;
  reg [7:0] short_slot_one_q;
  reg [7:0] short_slot_b_q;
  reg [`WINDOW_BASE_BITS-1:0] rom_window_base_q;
  reg [7:0] eff_addr_d;
  reg [7:0] rdata_d;
  reg [PC_W-1:0] pc_d;
  wire [15:0] opt_q;
  wire opt_valid;
  wire nmi_pin_s;
  wire low_supply_s;

  // address equality, used across decode
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // options are read only at reset; programming mode path is external
  option_latch u_opt (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .opt_word_i(opt_word_i),
    .opt_q_o(opt_q),
    .opt_valid_o(opt_valid)
  );

  sync2 u_nmi_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(nmi_pin_i),
    .q_o(nmi_pin_s)
  );

  sync2 u_lvd_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(low_supply_i),
    .q_o(low_supply_s)
  );

  // indirect mode picks a pointer as the operand address
  always @* begin
    eff_addr_d = d_addr_i;
    if (d_indirect_i) begin
      eff_addr_d = d_ind_sel_i ? pointer_second_q : pointer_first_q;
    end
  end

  // working registers; no reset, contents undefined until written
  always @(posedge sys_clk_i) begin
    if (d_wr_i && hit(eff_addr_d, `ADDR_POINTER_FIRST)) begin
      pointer_first_q <= d_wdata_i;
    end
    if (d_wr_i && hit(eff_addr_d, `ADDR_POINTER_SECOND)) begin
      pointer_second_q <= d_wdata_i;
    end
    if (d_wr_i && hit(eff_addr_d, `ADDR_SHORT_SLOT_ONE)) begin
      short_slot_one_q <= d_wdata_i;
    end
    if (d_wr_i && hit(eff_addr_d, `ADDR_SHORT_SLOT_B)) begin
      short_slot_b_q <= d_wdata_i;
    end
    // top two bits dropped, not stored
    if (d_wr_i && hit(eff_addr_d, `ADDR_ROM_WINDOW_BASE)) begin
      rom_window_base_q <= d_wdata_i[`WINDOW_BASE_BITS-1:0];
    end
  end

  // accumulator: data space write beats alu load in the same cycle
  always @(posedge sys_clk_i) begin
    if (d_wr_i && hit(eff_addr_d, `ADDR_SUM_REGISTER)) begin
      sum_register_o <= d_wdata_i;
    end else if (acc_load_i) begin
      sum_register_o <= acc_data_i;
    end
  end

  // read mux; window base reads as zero since it is write only
  always @* begin
    rdata_d = 8'h00;
    if (eff_addr_d >= `WINDOW_LO && eff_addr_d <= `WINDOW_HI) begin
      rdata_d = pmem_data_i;
    end else if (hit(eff_addr_d, `ADDR_POINTER_FIRST)) begin
      rdata_d = pointer_first_q;
    end else if (hit(eff_addr_d, `ADDR_POINTER_SECOND)) begin
      rdata_d = pointer_second_q;
    end else if (hit(eff_addr_d, `ADDR_SHORT_SLOT_ONE)) begin
      rdata_d = short_slot_one_q;
    end else if (hit(eff_addr_d, `ADDR_SHORT_SLOT_B)) begin
      rdata_d = short_slot_b_q;
    end else if (hit(eff_addr_d, `ADDR_SUM_REGISTER)) begin
      rdata_d = sum_register_o;
    end else if (hit(eff_addr_d, `ADDR_ROM_WINDOW_BASE)) begin
      rdata_d = 8'h00;
    end
  end

  // program memory address: window read uses base concatenated with low six bits
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pmem_addr_o <= {PC_W{1'b0}};
      d_rdata_o <= 8'h00;
      d_eff_addr_o <= 8'h00;
    end else begin
      d_eff_addr_o <= eff_addr_d;
      if (d_rd_i) begin
        d_rdata_o <= rdata_d;
      end
      if (d_rd_i && eff_addr_d >= `WINDOW_LO && eff_addr_d <= `WINDOW_HI) begin
        pmem_addr_o <= {rom_window_base_q, eff_addr_d[5:0]};
      end else begin
        pmem_addr_o <= pc_d;
      end
    end
  end

  // fetch counter next value; reset vector wins, then nmi, then irq
  always @* begin
    pc_d = fetch_counter_o;
    if (vec_nmi_i) begin
      pc_d = `VEC_NMI;
    end else if (vec_irq_i) begin
      pc_d = `VEC_IRQ_BASE + {9'h000, vec_irq_num_i, 1'b0};
    end else if (pc_load_i) begin
      pc_d = pc_load_addr_i;
    end else if (pc_inc_i) begin
      pc_d = fetch_counter_o + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end

  // twelve-bit counter wraps inside program space
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_counter_o <= `VEC_RESET;
    end else begin
      fetch_counter_o <= pc_d;
    end
  end

  // option decode into registered control outputs
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_with_watchdog_en_o <= 1'b0;
      low_supply_reset_en_o <= 1'b0;
      osc_source_select_o <= 1'b0;
      timer_pin_pullup_en_o <= 1'b0;
      nmi_pin_pullup_en_o <= 1'b0;
      watchdog_hw_start_o <= 1'b0;
      clock_guard_en_o <= 1'b0;
      readout_protect_o <= 1'b1;
      ext_read_en_o <= 1'b0;
      stop_allow_o <= 1'b0;
      low_supply_rst_o <= 1'b0;
    end else begin
      stop_with_watchdog_en_o <= opt_q[`OPT_STOP_WITH_WATCHDOG_EN_BIT];
      low_supply_reset_en_o <= opt_q[`OPT_LVD_BIT];
      osc_source_select_o <= opt_q[`OPT_OSC_SOURCE_SELECT_BIT];
      timer_pin_pullup_en_o <= opt_q[`OPT_TIMER_PIN_PULLUP_EN_BIT];
      nmi_pin_pullup_en_o <= opt_q[`OPT_NMI_PULL_BIT];
      watchdog_hw_start_o <= opt_q[`OPT_WATCHDOG_HW_START_BIT];
      clock_guard_en_o <= opt_q[`OPT_CLOCK_GUARD_EN_BIT];
      // protected until options valid, avoids a readout window at startup
      readout_protect_o <= ~opt_valid | opt_q[`OPT_PROTECT_BIT];
      ext_read_en_o <= ext_read_req_i & prog_mode_i & opt_valid &
                       ~opt_q[`OPT_PROTECT_BIT];
      stop_allow_o <= stop_req_i & (~watchdog_active_i |
                      (opt_q[`OPT_STOP_WITH_WATCHDOG_EN_BIT] & nmi_pin_s));
      low_supply_rst_o <= opt_valid & opt_q[`OPT_LVD_BIT] & low_supply_s;
    end
  end
endmodule // core_regs
`default_nettype wire

// file: prog_side.sv
// program memory and option source model for the core register block
`timescale 1ns/1ps
`default_nettype none
module prog_side (
  input wire logic [11:0] pmem_addr_i,
  input wire logic use_alt_i,
  output logic [7:0] pmem_data_o,
  output logic [15:0] opt_word_o
);
  // bytes differ across windows, so a wrong base shows up
  assign pmem_data_o = pmem_addr_i[7:0] ^ pmem_addr_i[11:4];
  // reserved d15-d10 and d5 low, d4 high; two complementary sets
  assign opt_word_o = use_alt_i ? 16'h01da : 16'h0215;
endmodule // prog_side
`default_nettype wire

// file: core_regs_properties.sv
// port assertions for the core register block
`timescale 1ns/1ps
`default_nettype none
module core_regs_chk #(
  parameter PC_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] d_addr_i,
  input wire logic d_rd_i,
  input wire logic d_indirect_i,
  input wire logic [7:0] d_rdata_o,
  input wire logic [PC_W-1:0] pmem_addr_o,
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic vec_irq_i,
  input wire logic [1:0] vec_irq_num_i,
  input wire logic vec_nmi_i,
  input wire logic [PC_W-1:0] fetch_counter_o,
  input wire logic readout_protect_o,
  input wire logic ext_read_en_o,
  input wire logic low_supply_reset_en_o,
  input wire logic low_supply_rst_o,
  input wire logic watchdog_active_i,
  input wire logic stop_with_watchdog_en_o,
  input wire logic stop_allow_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_nmi; vec_nmi_i |=> fetch_counter_o == 12'h0ffc; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi vector wrong");
  property p_irq; vec_irq_i && !vec_nmi_i
    |=> fetch_counter_o == 12'h0ff0 + 2 * $past(vec_irq_num_i); endproperty
  a_irq: assert property (p_irq) else $error("irq vector wrong");
  property p_inc; pc_inc_i && !pc_load_i && !vec_irq_i && !vec_nmi_i
    |=> fetch_counter_o == $past(fetch_counter_o) + 1'b1; endproperty
  a_inc: assert property (p_inc) else $error("counter step wrong");
  property p_wo; d_rd_i && !d_indirect_i && d_addr_i == 8'hc9 |=> d_rdata_o == 8'h00;
  endproperty
  a_wo: assert property (p_wo) else $error("base read not zero");
  property p_win; d_rd_i && !d_indirect_i && d_addr_i[7:6] == 2'b01
    |=> pmem_addr_o[5:0] == $past(d_addr_i[5:0]); endproperty
  a_win: assert property (p_win) else $error("window offset wrong");
  // protect is forced high during reset, so the first edge is covered too
  property p_prot; $past(readout_protect_o) |-> !ext_read_en_o; endproperty
  a_prot: assert property (p_prot) else $error("readout not blocked");
  property p_lvr; !low_supply_reset_en_o |-> !low_supply_rst_o; endproperty
  a_lvr: assert property (p_lvr) else $error("supply reset when off");
  property p_stop; $past(watchdog_active_i) && !stop_with_watchdog_en_o |-> !stop_allow_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop allowed");
  property p_keep; $past(rst_b_i) && $past(rst_b_i, 2) && $past(rst_b_i, 3)
    |-> $stable(low_supply_reset_en_o) && $stable(readout_protect_o); endproperty
  a_keep: assert property (p_keep) else $error("option moved");
endmodule // core_regs_chk
bind core_regs core_regs_chk #(.PC_W(PC_W)) core_regs_chk_i (.sys_clk_i, .rst_b_i,
  .d_addr_i, .d_rd_i, .d_indirect_i, .d_rdata_o, .pmem_addr_o, .pc_inc_i, .pc_load_i,
  .vec_irq_i, .vec_irq_num_i, .vec_nmi_i, .fetch_counter_o, .readout_protect_o,
  .ext_read_en_o, .low_supply_reset_en_o, .low_supply_rst_o, .watchdog_active_i,
  .stop_with_watchdog_en_o, .stop_allow_o);
`default_nettype wire

// file: tb.sv
// self-checking bench for the core register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i, rst_b_i, d_wr_i, d_rd_i, d_indirect_i, d_ind_sel_i, acc_load_i, pc_inc_i;
  logic pc_load_i, vec_irq_i, vec_nmi_i, prog_mode_i, ext_read_req_i, nmi_pin_i, use_alt;
  logic watchdog_active_i, stop_req_i, low_supply_i, ext_read_en_o, stop_allow_o;
  logic low_supply_rst_o, stop_with_watchdog_en_o, low_supply_reset_en_o, osc_source_select_o;
  logic timer_pin_pullup_en_o, nmi_pin_pullup_en_o, watchdog_hw_start_o, clock_guard_en_o;
  logic readout_protect_o;
  logic [1:0] vec_irq_num_i;
  logic [7:0] d_addr_i, d_wdata_i, acc_data_i, d_rdata_o, d_eff_addr_o, sum_register_o;
  logic [7:0] pmem_data_i;
  logic [11:0] pc_load_addr_i, fetch_counter_o, pmem_addr_o;
  logic [15:0] opt_word_i, ow;
  logic [7:0] ra [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
  int failures = 0;
  int n_checks = 0;
  core_regs core_regs_i (.sys_clk_i, .rst_b_i, .d_addr_i, .d_wr_i, .d_rd_i, .d_wdata_i,
    .d_indirect_i, .d_ind_sel_i, .d_rdata_o, .d_eff_addr_o, .acc_load_i, .acc_data_i,
    .sum_register_o, .pc_inc_i, .pc_load_i, .pc_load_addr_i, .vec_irq_i, .vec_irq_num_i,
    .vec_nmi_i, .fetch_counter_o, .pmem_addr_o, .pmem_data_i, .prog_mode_i, .opt_word_i,
    .ext_read_req_i, .ext_read_en_o, .nmi_pin_i, .watchdog_active_i, .stop_req_i,
    .low_supply_i, .stop_allow_o, .low_supply_rst_o, .stop_with_watchdog_en_o,
    .low_supply_reset_en_o, .osc_source_select_o, .timer_pin_pullup_en_o,
    .nmi_pin_pullup_en_o, .watchdog_hw_start_o, .clock_guard_en_o, .readout_protect_o);
  prog_side prog_side_i (.pmem_addr_i(pmem_addr_o), .use_alt_i(use_alt),
    .pmem_data_o(pmem_data_i), .opt_word_o(opt_word_i));
  // 40 mhz clock
  initial begin
    sys_clk_i = 0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // inputs move 1 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // one idle edge first, so a strobe never drops and rises in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    d_addr_i = a;
    d_wdata_i = d;
    d_wr_i = 1;
    cyc(1);
    d_wr_i = 0;
  endtask
  // window data needs the address held two cycles
  task automatic rd(input logic [7:0] a, input logic ind, input logic sel, input int n);
    cyc(1);
    d_addr_i = a;
    d_indirect_i = ind;
    d_ind_sel_i = sel;
    d_rd_i = 1;
    cyc(n);
    d_rd_i = 0;
    d_indirect_i = 0;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    cyc(5000);
    failures++;
    finish_test();
  end
  initial begin
    {d_wr_i, d_rd_i, d_indirect_i, d_ind_sel_i, acc_load_i, pc_inc_i, pc_load_i} = '0;
    {vec_irq_i, vec_nmi_i, prog_mode_i, ext_read_req_i, nmi_pin_i, use_alt} = '0;
    {watchdog_active_i, stop_req_i, low_supply_i, vec_irq_num_i, pc_load_addr_i} = '0;
    {d_addr_i, d_wdata_i, acc_data_i} = '0;
    rst_b_i = 0;
    for (int k = 0; k < 2; k++) begin
      use_alt = k[0];
      rst_b_i = 0;
      cyc(20);
      rst_b_i = 1;
      cyc(3);
      ow = k ? 16'h01da : 16'h0215;
      chk("clock_guard_en", clock_guard_en_o, ow[0]);
      chk("watchdog_hw_start", watchdog_hw_start_o, ow[1]);
      chk("timpu", timer_pin_pullup_en_o, ow[2]);
      chk("nmipu", nmi_pin_pullup_en_o, ow[3]);
      chk("osc", osc_source_select_o, ow[6]);
      chk("prot", readout_protect_o, ow[7]);
      chk("lvd", low_supply_reset_en_o, ow[8]);
      chk("extc", stop_with_watchdog_en_o, ow[9]);
      chk("pcrst", fetch_counter_o, 12'h0ffe);
      // option source changes under a running device
      {prog_mode_i, ext_read_req_i, watchdog_active_i, stop_req_i} = 4'hf;
      {nmi_pin_i, low_supply_i} = 2'b11;
      use_alt = ~use_alt;
      cyc(6);
      chk("rdout", ext_read_en_o, !ow[7]);
      chk("stop", stop_allow_o, ow[9]);
      chk("lvr", low_supply_rst_o, ow[8]);
      chk("keep", {clock_guard_en_o, osc_source_select_o}, {ow[0], ow[6]});
      {prog_mode_i, ext_read_req_i, watchdog_active_i, stop_req_i, nmi_pin_i} = '0;
      low_supply_i = 0;
      cyc(4);
    end
    for (int i = 0; i < 5; i++) wr(ra[i], 8'ha0 + i);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], 0, 0, 1);
      chk("reg", d_rdata_o, 8'ha0 + i);
    end
    chk("acc", sum_register_o, 8'ha4);
    acc_data_i = 8'h5a;
    acc_load_i = 1;
    cyc(1);
    acc_load_i = 0;
    rd(8'hff, 0, 0, 1);
    chk("accld", d_rdata_o, 8'h5a);
    wr(8'h80, 8'h83);
    rd(8'h00, 1, 0, 1);
    chk("indx", {d_eff_addr_o, d_rdata_o[3:0]}, 12'h833);
    rd(8'h00, 1, 1, 1);
    chk("indy", d_eff_addr_o, 8'ha1);
    // top two bits set on purpose: they must not reach the window
    wr(8'h84, 8'hea); // unmapped address 84 written before the base; no register stores it
    wr(8'hc9, 8'hea);
    rd(8'hc9, 0, 0, 1);
    chk("wo", d_rdata_o, 8'h00);
    rd(8'h45, 0, 0, 2);
    chk("wadr", pmem_addr_o, 12'ha85);
    chk("wdat", d_rdata_o, 8'h85 ^ 8'ha8);
    rd(8'h10, 0, 0, 1);
    chk("unmap", d_rdata_o, 8'h00);
    vec_nmi_i = 1;
    cyc(1);
    vec_nmi_i = 0;
    chk("vnmi", fetch_counter_o, 12'h0ffc);
    {vec_irq_i, vec_irq_num_i} = 3'b111;
    cyc(1);
    vec_irq_i = 0;
    chk("virq", fetch_counter_o, 12'h0ff6);
    pc_load_addr_i = 12'h0fff;
    pc_load_i = 1;
    cyc(1);
    pc_load_i = 0;
    pc_inc_i = 1;
    cyc(1);
    pc_inc_i = 0;
    chk("wrap", fetch_counter_o, 12'h000);
    finish_test();
  end
endmodule // tb
`default_nettype wire
